// File: src/aasc_cfg.svh
/*
  timing, command and size constants for the auto-sample capture link.
  assumes a 200 MHz system clock on the host end.
*/
`ifndef AASC_CFG_SVH
`define AASC_CFG_SVH

// ----------------------------------------
// link timing
// ----------------------------------------
`define AASC_CORE_HALF_DIV    3
`define AASC_SCLK_DIV         3
`define AASC_SCLK_MHZ_X10     375
`define AASC_WORD_BITS        16
`define AASC_DATA_DELAY       1

// ----------------------------------------
// converter
// ----------------------------------------
`define AASC_CMD_READ_DATA    16'hD000
`define AASC_CONV_CYCLES      8

// ----------------------------------------
// capture
// ----------------------------------------
`define AASC_BLOCK_WORDS      65536
`define AASC_FIFO_DEPTH       16

`endif

// File: src/aasc_pkg.sv
/*
  types used by the host end of the capture link.
  assumes aasc_cfg.svh constants.
*/
package aasc_pkg;
    typedef enum logic [1:0] {AASC_IDLE, AASC_SHIFT, AASC_DONE} aasc_link_state_t;
    typedef enum logic [1:0] {AASC_FILL, AASC_SCRATCH, AASC_IRQ} aasc_cap_state_t;
endpackage : aasc_pkg

// File: src/aasc_link_if.sv
/*
  serial link between the converter end and the host end.
  assumes the host drives the serial clock and frame.
*/
`timescale 1ns/1ps
`default_nettype none
interface aasc_link_if;
    logic host_tx_clock;
    logic frame_n;
    logic host_sdi;
    logic adc_sdo;
    logic eoc;
    modport device (input host_tx_clock, input frame_n, input host_sdi,
                    output adc_sdo, output eoc);
    modport host (output host_tx_clock, output frame_n, output host_sdi,
                  input adc_sdo, input eoc);
endinterface : aasc_link_if
`default_nettype wire

// File: src/aasc_fifo.sv
/*
  parameterised valid/ready fifo used in the host sample path.
  assumes a single clock.
*/
`timescale 1ns/1ps
`default_nettype none
module aasc_fifo
    import aasc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
)(
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    wire              full_w  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    wire              empty_w = (wr_reg == rd_reg);
    wire              push_w  = in_valid_in && !full_w;
    wire              pop_w   = out_ready_in && !empty_w;

    assign in_ready_out  = !full_w;
    assign out_valid_out = !empty_w;
    assign out_data_out  = mem[rd_reg[AW-1:0]];

    always_ff @(posedge clk_in)
    begin
        if (push_w)
        begin
            mem[wr_reg[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_reg + (AW+1)'(push_w);
            rd_reg <= rd_reg + (AW+1)'(pop_w);
        end
    end
endmodule : aasc_fifo
`default_nettype wire

// File: src/aasc_host.sv
/*
  host end: serial port, command fetch on eoc fall, sample store,
  scratch after full block, completion interrupt and restart.
  assumes the converter end on the link interface.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aasc_cfg.svh"
// Function
// [R01] converter converts on its internal clock
// [R02] converter self-triggers and alternates channels
// [R03] eoc high, falls when result ready
// [R04] eoc fall sends read command to transmit (code skips it while the fifo is full)
// [R05] no power-down, no channel tag bit
// [R06] serial clock is half core over three
// [R07] clock-stop mode, 16-bit words only
// [R08] host drives serial clock from divider
// [R09] outgoing data delayed one clock
// [R10] receive sampled on the driven clock
// [R11] each command write starts one frame
// [R12] each received word stored until block full
// [R13] after full, words go to scratch
// [R14] completion raises interrupt
// [R15] service resets and restarts acquisition
// [R16] each frame returns latest result
module aasc_host
    import aasc_pkg::*;
#(
    parameter int BLOCK_WORDS = `AASC_BLOCK_WORDS,
    parameter int FIFO_DEPTH  = `AASC_FIFO_DEPTH
)(
    input  wire logic   clk_in,
    input  wire logic   reset_in,
    aasc_link_if.host   link,
    output logic        mem_we_out,
    output logic [15:0] mem_addr_out,
    output logic [15:0] mem_data_out,
    input  wire logic   mem_ready_in,
    output logic [15:0] scratch_out,
    output logic        irq_out,
    input  wire logic   irq_service_in
);
    localparam int DIV = `AASC_CORE_HALF_DIV * 2;
    localparam int HALF = DIV / 2;

    // ----------------------------------------
    // eoc synchroniser
    // ----------------------------------------
    logic eoc_s1_reg;
    logic eoc_s2_reg;
    logic eoc_s3_reg;
    wire  eoc_fall_w = eoc_s3_reg && !eoc_s2_reg;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            eoc_s1_reg <= 1'b1;
            eoc_s2_reg <= 1'b1;
            eoc_s3_reg <= 1'b1;
        end
        else
        begin
            eoc_s1_reg <= link.eoc;
            eoc_s2_reg <= eoc_s1_reg;
            eoc_s3_reg <= eoc_s2_reg;
        end
    end

    // ----------------------------------------
    // command fetch and serial port
    // ----------------------------------------
    aasc_link_state_t state_reg;
    logic [15:0] tx_data_reg;
    logic        tx_pending_reg;
    logic [15:0] shift_tx_reg;
    logic [15:0] shift_rx_reg;
    logic [4:0]  bit_reg;
    logic [2:0]  div_reg;
    logic        sclk_reg;
    logic        frame_n_reg;
    logic        sdi_reg;
    logic        rx_valid_reg;
    logic [15:0] rx_data_reg;
    logic        run_reg;
    wire         rise_w = (div_reg == 3'(HALF - 1)) && !sclk_reg;
    wire         fall_w = (div_reg == 3'(HALF - 1)) && sclk_reg;

    assign link.host_tx_clock = sclk_reg; // [R08]
    assign link.frame_n       = frame_n_reg;
    assign link.host_sdi      = sdi_reg;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_reg      <= AASC_IDLE;
            tx_data_reg    <= 16'h0000;
            tx_pending_reg <= 1'b0;
            shift_tx_reg   <= 16'h0000;
            shift_rx_reg   <= 16'h0000;
            bit_reg        <= 5'h00;
            div_reg        <= 3'h0;
            sclk_reg       <= 1'b0;
            frame_n_reg    <= 1'b1;
            sdi_reg        <= 1'b0;
            rx_valid_reg   <= 1'b0;
            rx_data_reg    <= 16'h0000;
        end
        else
        begin
            rx_valid_reg <= 1'b0;
            if (eoc_fall_w && run_reg)
            begin
                tx_data_reg    <= `AASC_CMD_READ_DATA; // [R04]
                tx_pending_reg <= 1'b1;
            end
            case (state_reg)
                AASC_IDLE:
                begin
                    sclk_reg <= 1'b0; // [R07]
                    div_reg  <= 3'h0;
                    if (tx_pending_reg && !(eoc_fall_w && run_reg))
                    begin
                        tx_pending_reg <= 1'b0;
                        shift_tx_reg   <= tx_data_reg; // [R11]
                        frame_n_reg    <= 1'b0;
                        bit_reg        <= 5'h00;
                        state_reg      <= AASC_SHIFT;
                    end
                end
                AASC_SHIFT:
                begin
                    div_reg <= (div_reg == 3'(HALF - 1)) ? 3'h0 : div_reg + 3'h1; // [R06]
                    if (rise_w)
                    begin
                        sclk_reg     <= 1'b1;
                        shift_rx_reg <= {shift_rx_reg[14:0], link.adc_sdo}; // [R10]
                        bit_reg      <= bit_reg + 5'h01;
                    end
                    else if (fall_w)
                    begin
                        sclk_reg     <= 1'b0;
                        sdi_reg      <= shift_tx_reg[15]; // [R09]
                        shift_tx_reg <= {shift_tx_reg[14:0], 1'b0};
                        if (bit_reg == 5'(`AASC_WORD_BITS + `AASC_DATA_DELAY))
                        begin
                            state_reg <= AASC_DONE;
                        end
                    end
                end
                AASC_DONE:
                begin
                    frame_n_reg  <= 1'b1;
                    sdi_reg      <= 1'b0;
                    rx_data_reg  <= shift_rx_reg;
                    rx_valid_reg <= 1'b1;
                    state_reg    <= AASC_IDLE;
                end
                default:
                begin
                    state_reg <= AASC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // receive buffer and block store
    // ----------------------------------------
    logic        f_valid_w;
    logic [15:0] f_data_w;
    logic        f_in_ready_w;
    aasc_cap_state_t cap_reg;
    logic [16:0] count_reg;
    wire         take_w = f_valid_w && (cap_reg != AASC_FILL || mem_ready_in);

    aasc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in || (cap_reg == AASC_IRQ && irq_service_in)),
        .in_valid_in   (rx_valid_reg),
        .in_ready_out  (f_in_ready_w),
        .in_data_in    (rx_data_reg),
        .out_valid_out (f_valid_w),
        .out_ready_in  (cap_reg != AASC_FILL || mem_ready_in),
        .out_data_out  (f_data_w)
    );

    assign run_reg    = f_in_ready_w;
    assign mem_we_out = f_valid_w && cap_reg == AASC_FILL;
    assign mem_addr_out = count_reg[15:0];
    assign mem_data_out = f_data_w;
    assign irq_out      = (cap_reg == AASC_IRQ);

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            cap_reg     <= AASC_FILL;
            count_reg   <= 17'h00000;
            scratch_out <= 16'h0000;
        end
        else
        begin
            case (cap_reg)
                AASC_FILL:
                begin
                    if (take_w)
                    begin
                        count_reg <= count_reg + 17'h00001; // [R12]
                        if (count_reg == 17'(BLOCK_WORDS - 1))
                        begin
                            cap_reg <= AASC_IRQ; // [R14]
                        end
                    end
                end
                AASC_IRQ, AASC_SCRATCH:
                begin
                    if (take_w)
                    begin
                        scratch_out <= f_data_w; // [R13]
                    end
                    if (cap_reg == AASC_IRQ && irq_service_in)
                    begin
                        count_reg <= 17'h00000; // [R15]
                        cap_reg   <= AASC_FILL;
                    end
                end
                default:
                begin
                    cap_reg <= AASC_FILL;
                end
            endcase
        end
    end
endmodule : aasc_host
`default_nettype wire

// File: src/aasc_adc.sv
/*
  converter end: self-timed conversions on an internal clock,
  alternating channels, eoc output and serial readout.
  assumes the host clocks frames on the link.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aasc_cfg.svh"
module aasc_adc
    import aasc_pkg::*;
#(
    parameter int CONV_CYCLES = `AASC_CONV_CYCLES
)(
    input  wire logic        conv_clk_in,
    input  wire logic        reset_in,
    input  wire logic [15:0] ch0_sample_in,
    input  wire logic [15:0] ch1_sample_in,
    aasc_link_if.device      link
);
    // ----------------------------------------
    // conversion engine
    // ----------------------------------------
    logic [7:0]       conv_cnt_reg;
    logic             chan_reg;
    logic [15:0]      result_reg;
    logic             eoc_reg;
    logic [1:0][15:0] samp_s1_reg;
    logic [1:0][15:0] samp_s2_reg;

    assign link.eoc = eoc_reg;

    // analog stand-ins pass two stages before a conversion reads them
    always_ff @(posedge conv_clk_in)
    begin
        samp_s1_reg <= {ch1_sample_in, ch0_sample_in};
        samp_s2_reg <= samp_s1_reg;
    end

    always_ff @(posedge conv_clk_in)
    begin
        if (reset_in)
        begin
            conv_cnt_reg <= 8'h00;
            chan_reg     <= 1'b0;
            result_reg   <= 16'h0000;
            eoc_reg      <= 1'b1;
        end
        else
        begin
            conv_cnt_reg <= (conv_cnt_reg == 8'(CONV_CYCLES - 1)) ? 8'h00
                          : conv_cnt_reg + 8'h01; // [R01] [R02]
            eoc_reg      <= (conv_cnt_reg >= 8'(CONV_CYCLES / 2)); // [R03]
            // result lands on the edge that drops eoc and stands a whole conversion
            if (conv_cnt_reg == 8'h00)
            begin
                result_reg <= samp_s2_reg[chan_reg]; // [R05]
                chan_reg   <= !chan_reg; // [R02]
            end
        end
    end

    // ----------------------------------------
    // serial readout on the link clock
    // ----------------------------------------
    // result_reg is read without a synchroniser: frames only follow an eoc fall,
    // and the result stays still until the next conversion ends
    logic [4:0]  fall_cnt_reg;
    logic [15:0] sh_reg;

    always_ff @(negedge link.host_tx_clock or posedge link.frame_n)
    begin
        if (link.frame_n)
        begin
            fall_cnt_reg <= 5'h00;
            sh_reg       <= 16'h0000;
        end
        else
        begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
            sh_reg       <= (fall_cnt_reg == 5'h00) ? result_reg : {sh_reg[14:0], 1'b0};
        end
    end

    // first clock of a frame is the delay bit, msb follows its falling edge
    assign link.adc_sdo = (fall_cnt_reg != 5'h00) ? sh_reg[15] : 1'b0; // [R16]
endmodule : aasc_adc
`default_nettype wire

// File: verif/aasc_link_props.sv
/*
  link checker for the capture link: serial clock shape, framing, command word.
  assumes it watches the link interface and the host clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aasc_cfg.svh"
module aasc_link_props (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic host_tx_clock,
    input wire logic frame_n,
    input wire logic host_sdi,
    input wire logic adc_sdo,
    input wire logic eoc
);
    // ----------------------------------------
    // helper logic
    // ----------------------------------------
    logic [5:0]  rise_cnt_reg;
    logic [16:0] sdi_bits_reg;
    logic [3:0]  pend_reg;
    logic        sclk_q_reg;
    logic        rise_d_reg;
    logic        eoc_q_reg;
    logic        frame_q_reg;
    wire logic       sclk_rise  = host_tx_clock && !sclk_q_reg;
    wire logic       eoc_fall   = !eoc && eoc_q_reg;
    wire logic       frame_fall = frame_q_reg && !frame_n;
    wire logic [3:0] pend_inc   = {3'h0, eoc_fall && (pend_reg != 4'hF)};
    wire logic [3:0] pend_dec   = {3'h0, frame_fall && (pend_reg != 4'h0)};
    wire logic [3:0] pend_next  = pend_reg + pend_inc - pend_dec;

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            rise_cnt_reg <= 6'h00;
            sdi_bits_reg <= 17'h00000;
            pend_reg     <= 4'h0;
            sclk_q_reg   <= 1'b0;
            rise_d_reg   <= 1'b0;
            eoc_q_reg    <= 1'b1;
            frame_q_reg  <= 1'b1;
        end
        else
        begin
            rise_cnt_reg <= frame_fall ? 6'h00 : rise_cnt_reg + {5'h00, sclk_rise};
            sdi_bits_reg <= rise_d_reg ? {sdi_bits_reg[15:0], host_sdi} : sdi_bits_reg;
            pend_reg     <= pend_next;
            sclk_q_reg   <= host_tx_clock;
            rise_d_reg   <= sclk_rise;
            eoc_q_reg    <= eoc;
            frame_q_reg  <= frame_n;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    AST_SCLK_STOP: assert property (frame_n |-> !host_tx_clock)
        else $error("serial clock runs outside a frame");
    AST_SCLK_HIGH: assert property ($rose(host_tx_clock) |-> host_tx_clock[*3] ##1 !host_tx_clock)
        else $error("serial clock high phase wrong");
    AST_SCLK_LOW: assert property ($fell(host_tx_clock) && !frame_n |-> !host_tx_clock[*3])
        else $error("serial clock low phase wrong");
    AST_FRAME_START: assert property ($fell(frame_n) |-> ##[1:12] $rose(host_tx_clock))
        else $error("frame started without serial clock");
    AST_FRAME_LEN: assert property ($rose(frame_n) |-> rise_cnt_reg == 6'h11)
        else $error("frame clock count wrong");
    AST_CMD_WORD: assert property ($rose(frame_n) |-> (sdi_bits_reg[15:0] == `AASC_CMD_READ_DATA)
        || (sdi_bits_reg[16:1] == `AASC_CMD_READ_DATA))
        else $error("command word wrong");
    AST_FRAME_NEEDS_EOC: assert property (frame_fall |-> pend_reg != 4'h0)
        else $error("frame without end of conversion");
    AST_RESET_IDLE: assert property ($fell(reset_in) |-> frame_n && !host_tx_clock)
        else $error("link not idle after reset");
    AST_SDO_IDLE: assert property (frame_n |-> !adc_sdo)
        else $error("converter data driven outside a frame");
endmodule : aasc_link_props
`default_nettype wire

// File: verif/adc_auto_sample_capture_tb_top.sv
/*
  testbench for the capture link: both ends joined, stores collected and checked.
  assumes small block size and an 80 ns conversion clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_auto_sample_capture_tb_top;
    import aasc_pkg::*;
    localparam int BLK = 8;
    logic        clk_in;
    logic        conv_clk;
    logic        host_reset;
    logic        adc_reset;
    logic        mem_ready;
    logic        irq_service;
    logic [15:0] ch0_val;
    logic [15:0] ch1_val;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_data;
    logic [15:0] scratch;
    logic        irq;
    logic [15:0] addr_q[$];
    logic [15:0] data_q[$];
    int          num_errors;
    int          total_checks;

    // ----------------------------------------
    // design and checker
    // ----------------------------------------
    aasc_link_if link_if ();
    aasc_host #(.BLOCK_WORDS(BLK), .FIFO_DEPTH(16)) u_aasc_host (.clk_in(clk_in),
        .reset_in(host_reset), .link(link_if), .mem_we_out(mem_we), .mem_addr_out(mem_addr),
        .mem_data_out(mem_data), .mem_ready_in(mem_ready), .scratch_out(scratch),
        .irq_out(irq), .irq_service_in(irq_service));
    aasc_adc u_aasc_adc (.conv_clk_in(conv_clk), .reset_in(adc_reset),
        .ch0_sample_in(ch0_val), .ch1_sample_in(ch1_val), .link(link_if));
    aasc_link_props u_aasc_link_props (.clk_in(clk_in), .reset_in(host_reset),
        .host_tx_clock(link_if.host_tx_clock), .frame_n(link_if.frame_n),
        .host_sdi(link_if.host_sdi), .adc_sdo(link_if.adc_sdo), .eoc(link_if.eoc));

    // ----------------------------------------
    // clocks and store monitor
    // ----------------------------------------
    initial clk_in = 1'b0;
    always #2.5 clk_in = ~clk_in;
    initial
    begin
        conv_clk = 1'b0;
        #1.3;
        forever #40 conv_clk = ~conv_clk;
    end
    always @(posedge clk_in)
    begin
        if (mem_we && mem_ready)
        begin
            addr_q.push_back(mem_addr);
            data_q.push_back(mem_data);
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic run_block(input logic [15:0] a, input logic [15:0] b, input int settle,
                             input logic [15:0] scr);
        int k;
        k = 0;
        while (addr_q.size() < BLK && k < 40000)
        begin
            @(negedge clk_in);
            k++;
        end
        check("words stored", 16'(BLK), 16'(addr_q.size()));
        check("first word", a, data_q[0]);
        for (int i = 0; i < BLK; i++)
        begin
            check("address", 16'(i), addr_q[i]);
            check("channel word", (i % 2 == 0) ? a : b, data_q[i]);
        end
        repeat (4) @(negedge clk_in);
        check("irq raised", 16'h0001, {15'h0000, irq});
        repeat (settle) @(negedge clk_in);
        check("scratch word", scr, scratch);
        repeat (1500 - settle) @(negedge clk_in);
        check("stores after full", 16'(BLK), 16'(addr_q.size()));
        check("irq held", 16'h0001, {15'h0000, irq});
    endtask : run_block

    task automatic end_of_test();
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        num_errors = 0;
        total_checks = 0;
        host_reset = 1'b1;
        adc_reset = 1'b1;
        mem_ready = 1'b1;
        irq_service = 1'b0;
        ch0_val = 16'h1234;
        ch1_val = 16'hABCD;
        repeat (16) @(negedge clk_in);
        host_reset = 1'b0;
        repeat (48) @(negedge clk_in);
        adc_reset = 1'b0;
        run_block(16'h1234, 16'hABCD, 188, 16'h1234);
        adc_reset = 1'b1;
        ch0_val = 16'h0F0F;
        ch1_val = 16'hF0F0;
        repeat (600) @(negedge clk_in);
        irq_service = 1'b1;
        @(negedge clk_in);
        irq_service = 1'b0;
        addr_q.delete();
        data_q.delete();
        mem_ready = 1'b0;
        repeat (3) @(negedge clk_in);
        check("irq cleared", 16'h0000, {15'h0000, irq});
        adc_reset = 1'b0;
        repeat (3000) @(negedge clk_in);
        check("word offered", 16'h0001, {15'h0000, mem_we});
        check("stalled stores", 16'h0000, 16'(addr_q.size()));
        mem_ready = 1'b1;
        run_block(16'h0F0F, 16'hF0F0, 16, 16'hF0F0);
        end_of_test();
    end

    initial
    begin
        #200000;
        num_errors++;
        end_of_test();
    end
endmodule : adc_auto_sample_capture_tb_top
`default_nettype wire
